// ===== hdl/cvs_pkg.sv
// Package with constants and types of the camera video sync timing generator
package cvs_pkg;

  // System clock period in nanoseconds
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Readout mode codes on the mode select input
  localparam logic [1:0] MODE_INTERLACE = 2'h0;
  localparam logic [1:0] MODE_BIN2 = 2'h1;
  localparam logic [1:0] MODE_BIN4 = 2'h2;
  localparam logic [1:0] MODE_OUTLINE = 2'h3;

  // Pixel strobe periods per mode in nanoseconds
  localparam int unsigned STROBE_NS_INTERLACE = 50;
  localparam int unsigned STROBE_NS_BIN2 = 100;
  localparam int unsigned STROBE_NS_BIN4 = 200;
  localparam int unsigned STROBE_NS_OUTLINE = 300;

  // Half strobe period in system clock cycles, rounded down, at least one
  localparam int unsigned HALF_INTERLACE = STROBE_NS_INTERLACE / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_BIN2 = STROBE_NS_BIN2 / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_BIN4 = STROBE_NS_BIN4 / (2 * CLK_PERIOD_NS);
  localparam int unsigned HALF_OUTLINE = STROBE_NS_OUTLINE / (2 * CLK_PERIOD_NS);

  // Width of the half period counter
  localparam int unsigned HALF_W = 6;

  // Line cycle: inactive and active strobe counts per mode
  localparam int unsigned LINE_OFF_INTERLACE = 428;
  localparam int unsigned LINE_ON_INTERLACE = 4000;
  localparam int unsigned LINE_OFF_BIN2 = 246;
  localparam int unsigned LINE_ON_BIN2 = 2000;
  localparam int unsigned LINE_OFF_BIN4 = 123;
  localparam int unsigned LINE_ON_BIN4 = 1000;
  localparam int unsigned LINE_OFF_OUTLINE = 74;
  localparam int unsigned LINE_ON_OUTLINE = 664;

  // Frame cycle: inactive and active line counts per mode
  localparam int unsigned FRAME_OFF_LINES = 4;
  localparam int unsigned FRAME_ON_INTERLACE = 2624;
  localparam int unsigned FRAME_ON_BIN2 = 1312;
  localparam int unsigned FRAME_ON_BIN4 = 656;
  localparam int unsigned FRAME_ON_OUTLINE = 442;

  // Counter and pixel word widths
  localparam int unsigned PIX_W = 13;
  localparam int unsigned LINE_W = 12;
  localparam int unsigned WORD_W = 12;

  // Strobe count inside the inactive interval at which frame valid may move
  localparam logic [PIX_W-1:0] FRAME_MOVE_PIX = 13'h0001;

  // Outgoing video qualifiers and pixel word
  typedef struct packed {
    logic strobe;
    logic line_valid;
    logic frame_valid;
    logic [WORD_W-1:0] word;
  } cvs_video_type;

  // Per mode timing set
  typedef struct packed {
    logic [HALF_W-1:0] half;
    logic [PIX_W-1:0] first_interval_count;
    logic [PIX_W-1:0] second_interval_count;
    logic [LINE_W-1:0] frame_lines;
  } cvs_timing_type;

  // Timing set looked up from the readout mode
  function automatic cvs_timing_type cvs_timing(input logic [1:0] mode);
    cvs_timing_type t;
    t = '0;
    unique case (mode)
      MODE_INTERLACE: begin
        t.half = HALF_W'(HALF_INTERLACE);
        t.first_interval_count = PIX_W'(LINE_OFF_INTERLACE);
        t.second_interval_count = PIX_W'(LINE_ON_INTERLACE);
        t.frame_lines = LINE_W'(FRAME_ON_INTERLACE);
      end
      MODE_BIN2: begin
        t.half = HALF_W'(HALF_BIN2);
        t.first_interval_count = PIX_W'(LINE_OFF_BIN2);
        t.second_interval_count = PIX_W'(LINE_ON_BIN2);
        t.frame_lines = LINE_W'(FRAME_ON_BIN2);
      end
      MODE_BIN4: begin
        t.half = HALF_W'(HALF_BIN4);
        t.first_interval_count = PIX_W'(LINE_OFF_BIN4);
        t.second_interval_count = PIX_W'(LINE_ON_BIN4);
        t.frame_lines = LINE_W'(FRAME_ON_BIN4);
      end
      MODE_OUTLINE: begin
        t.half = HALF_W'(HALF_OUTLINE);
        t.first_interval_count = PIX_W'(LINE_OFF_OUTLINE);
        t.second_interval_count = PIX_W'(LINE_ON_OUTLINE);
        t.frame_lines = LINE_W'(FRAME_ON_OUTLINE);
      end
    endcase
    return t;
  endfunction

endpackage

// ===== hdl/cvs_strobe_div.sv
// Pixel strobe divider: makes the strobe and marks its falling edges
module cvs_strobe_div (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Half period length in system clocks
  input wire logic [cvs_pkg::HALF_W-1:0] half,
  // Strobe level and falling edge pulse
  output logic strobe,
  output logic fall
);

  logic [cvs_pkg::HALF_W-1:0] count; // Cycles left in this half period
  logic [cvs_pkg::HALF_W-1:0] next_count;
  logic next_strobe;
  logic next_fall;

  // Toggle the strobe after each half period
  always_comb begin
    next_count = count;
    next_strobe = strobe;
    next_fall = 1'b0;
    if (count <= cvs_pkg::HALF_W'(1)) begin
      // Half period over: flip the level
      next_count = half;
      next_strobe = ~strobe;
      next_fall = strobe;
    end else begin
      // Still inside the half period
      next_count = count - cvs_pkg::HALF_W'(1);
    end
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      strobe <= 1'b0;
      fall <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      strobe <= next_strobe;
      fall <= next_fall;
    end
  end

endmodule

// ===== hdl/cvs_timing_gen.sv
// Camera video sync timing generator: strobe, line and frame qualifiers, pixel word
// Behaviour
// [R01] Interlace and 2x2 line interval counts
// [R02] 4x4 and outline line interval counts
// [R03] Frame: 4 blank lines, then mode lines
// [R04] Line valid moves on strobe falling edge
// [R05] Frame valid moves only while line low
// [R06] Frame valid never moves on strobe rise
// [R07] Strobe period follows readout mode
// [R08] Twelve bit pixel word follows strobe
// [R09] Qualifiers mark active line and frame
// [R10] First interval inactive, frame units lines
module cvs_timing_gen (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Readout mode select pins
  input wire logic [1:0] mode_sel,
  // Pixel samples from the converter, same clock
  input wire logic [cvs_pkg::WORD_W-1:0] pixel_in,
  // Video outputs to the frame grabber
  output logic pixel_strobe,
  output logic line_valid,
  output logic frame_valid,
  output logic [cvs_pkg::WORD_W-1:0] pixel_word,
  // Request for the next pixel sample, one cycle pulse
  output logic pixel_take
);

  // Mode pin synchroniser
  logic [1:0] mode_meta; // First stage, read only by the second
  logic [1:0] mode_sync; // Second stage

  // Timing state
  logic [1:0] mode; // Mode in use for this frame
  logic [1:0] next_mode;
  logic [cvs_pkg::PIX_W-1:0] pix_cnt; // Strobe within the line cycle
  logic [cvs_pkg::PIX_W-1:0] next_pix_cnt;
  logic [cvs_pkg::LINE_W-1:0] line_cnt; // Line within the frame cycle
  logic [cvs_pkg::LINE_W-1:0] next_line_cnt;
  cvs_pkg::cvs_video_type video; // Registered outputs
  cvs_pkg::cvs_video_type next_video;
  logic next_take;

  // Divider signals
  cvs_pkg::cvs_timing_type tim; // Timing for the current mode
  logic div_strobe; // Divider strobe level
  logic div_fall; // Divider falling edge pulse

  assign tim = cvs_pkg::cvs_timing(mode);

  // Strobe divider, half period from the current mode
  cvs_strobe_div u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .half(tim.half), // [R07]
    .strobe(div_strobe),
    .fall(div_fall)
  );

  // Two flip-flop synchroniser for the mode pins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_meta <= cvs_pkg::MODE_INTERLACE;
      mode_sync <= cvs_pkg::MODE_INTERLACE;
    end else if (clk_en) begin
      mode_meta <= mode_sel;
      mode_sync <= mode_meta;
    end
  end

  // Next state of counters and outputs
  always_comb begin
    next_mode = mode;
    next_pix_cnt = pix_cnt;
    next_line_cnt = line_cnt;
    next_video = video;
    next_take = 1'b0;
    // Strobe follows the divider one cycle late, like the qualifiers
    next_video.strobe = div_strobe;
    if (div_fall) begin
      // Everything below launches on a strobe falling edge
      next_take = 1'b1;
      if (pix_cnt == tim.first_interval_count + tim.second_interval_count - cvs_pkg::PIX_W'(1)) begin
        // End of a line cycle
        next_pix_cnt = '0; // [R01] [R02]
        if (line_cnt == tim.frame_lines + cvs_pkg::LINE_W'(cvs_pkg::FRAME_OFF_LINES) - cvs_pkg::LINE_W'(1)) begin
          // End of a frame cycle: pick up a new mode here only
          next_line_cnt = '0; // [R03]
          next_mode = mode_sync; // [R07]
        end else begin
          // Next line of the frame
          next_line_cnt = line_cnt + cvs_pkg::LINE_W'(1);
        end
      end else begin
        // Next strobe of the line
        next_pix_cnt = pix_cnt + cvs_pkg::PIX_W'(1);
      end
      // Line valid: inactive interval first, then active interval
      next_video.line_valid = (next_pix_cnt >= tim.first_interval_count); // [R04] [R09] [R10]
      // Frame valid moves one strobe into the inactive line interval
      if (next_pix_cnt == cvs_pkg::FRAME_MOVE_PIX) begin
        next_video.frame_valid = (line_cnt >= cvs_pkg::LINE_W'(cvs_pkg::FRAME_OFF_LINES)); // [R05] [R06] [R09] [R10]
      end
      // Pixel word launched with the strobe falling edge, zero when blank
      if (next_video.line_valid && next_video.frame_valid) begin
        next_video.word = pixel_in; // [R08]
      end else begin
        next_video.word = '0;
      end
    end
  end

  // Registers, frozen while the enable is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode <= cvs_pkg::MODE_INTERLACE;
      pix_cnt <= '0;
      line_cnt <= '0;
      video <= '0;
      pixel_take <= 1'b0;
    end else if (clk_en) begin
      mode <= next_mode;
      pix_cnt <= next_pix_cnt;
      line_cnt <= next_line_cnt;
      video <= next_video;
      pixel_take <= next_take;
    end
  end

  // Outputs straight from the output register
  assign pixel_strobe = video.strobe;
  assign line_valid = video.line_valid;
  assign frame_valid = video.frame_valid;
  assign pixel_word = video.word;

endmodule

// ===== verification/cvs_timing_props.sv
// Checker of the video qualifier timing seen at the generator ports
module cvs_timing_props (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Video outputs
  input wire logic pixel_strobe,
  input wire logic line_valid,
  input wire logic frame_valid,
  input wire logic [cvs_pkg::WORD_W-1:0] pixel_word,
  input wire logic pixel_take
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] half_n; // Enabled cycles since the last strobe change
  logic seen; // First strobe change after reset is passed
  logic [12:0] lo_n; // Strobe falls in the low part of a line
  logic [12:0] hi_n; // Strobe falls in the high part of a line
  logic [11:0] fv_lo_n; // Lines begun while frame valid is low
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Interval counters; reset counts as the fall of strobe count zero
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      half_n <= 6'h00;
      seen <= 1'b0;
      lo_n <= 13'h0001;
      hi_n <= 13'h0000;
      fv_lo_n <= 12'h000;
    end else begin
      half_n <= $changed(pixel_strobe) ? 6'h01 : (clk_en ? half_n + 6'h01 : half_n);
      seen <= seen | $changed(pixel_strobe);
      if ($fell(pixel_strobe) && line_valid) hi_n <= $rose(line_valid) ? 13'h0001 : hi_n + 13'h0001;
      if ($fell(pixel_strobe) && !line_valid) lo_n <= $fell(line_valid) ? 13'h0001 : lo_n + 13'h0001;
      if ($fell(frame_valid)) fv_lo_n <= 12'h000;
      else if ($rose(line_valid) && !frame_valid) fv_lo_n <= fv_lo_n + 12'h001;
    end
  end
  // A falling edge of the strobe
  sequence s_fall;
    $fell(pixel_strobe);
  endsequence
  property p_lv_edge; $changed(line_valid) |-> s_fall; endproperty
  property p_lo_len; $rose(line_valid) |-> lo_n inside {13'h01ac, 13'h00f6, 13'h007b, 13'h004a}; endproperty
  property p_hi_len; $fell(line_valid) |-> hi_n inside {13'h0fa0, 13'h07d0, 13'h03e8, 13'h0298}; endproperty
  property p_fv_blank; $rose(frame_valid) |-> fv_lo_n == 12'h004; endproperty
  property p_fv_lv_low; $changed(frame_valid) |-> !line_valid && !$past(line_valid); endproperty
  property p_fv_no_rise; $changed(frame_valid) |-> !$rose(pixel_strobe); endproperty
  property p_half; $changed(pixel_strobe) && seen |-> half_n inside {6'h05, 6'h0a, 6'h14, 6'h1e}; endproperty
  property p_take; s_fall |-> pixel_take; endproperty
  property p_word_hold; !$fell(pixel_strobe) |-> $stable(pixel_word); endproperty
  property p_word_blank; !(line_valid && frame_valid) |-> pixel_word == 12'h000; endproperty
  a_lv_edge: assert property (p_lv_edge) else $error("line valid moved off a strobe fall");
  a_lo_len: assert property (p_lo_len) else $error("line low part has a wrong length");
  a_hi_len: assert property (p_hi_len) else $error("line high part has a wrong length");
  a_fv_blank: assert property (p_fv_blank) else $error("frame blank part is not four lines");
  a_fv_lv_low: assert property (p_fv_lv_low) else $error("frame valid moved while line valid high");
  a_fv_no_rise: assert property (p_fv_no_rise) else $error("frame valid moved on a strobe rise");
  a_half: assert property (p_half) else $error("strobe half period is wrong");
  a_take: assert property (p_take) else $error("no sample request at a strobe fall");
  a_word_hold: assert property (p_word_hold) else $error("pixel word moved off a strobe fall");
  a_word_blank: assert property (p_word_blank) else $error("pixel word not zero outside the image");
endmodule
bind cvs_timing_gen cvs_timing_props u_props (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
  .pixel_strobe(pixel_strobe), .line_valid(line_valid), .frame_valid(frame_valid),
  .pixel_word(pixel_word), .pixel_take(pixel_take));

// ===== verification/cvs_grabber_model.sv
// Frame grabber model: measures strobe period and line intervals
module cvs_grabber_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Video from the camera
  input wire logic pixel_strobe,
  input wire logic line_valid,
  input wire logic frame_valid,
  input wire logic [cvs_pkg::WORD_W-1:0] pixel_word,
  // Measurements
  output logic [15:0] lo_run,
  output logic [15:0] hi_run,
  output logic [15:0] period,
  output logic word_bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sp; // Strobe level seen last cycle
  logic lv; // Line valid seen at the last fall
  logic [15:0] run; // Falls since the last line valid change
  logic [15:0] cyc; // Cycles since the last fall
  // Lines are framed by the qualifiers sampled at each strobe fall
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {sp, lv, word_bad} <= 3'h0;
      {lo_run, hi_run, period, cyc} <= 64'h0;
      run <= 16'h0001;
    end else begin
      cyc <= cyc + 16'h0001;
      if (sp && !pixel_strobe) begin
        period <= cyc + 16'h0001;
        cyc <= 16'h0000;
        if (line_valid !== lv) begin
          if (line_valid) lo_run <= run;
          else hi_run <= run;
          run <= 16'h0001;
        end else run <= run + 16'h0001;
        lv <= line_valid;
        if (!(line_valid && frame_valid) && pixel_word !== 12'h000) word_bad <= 1'b1;
      end
      sp <= pixel_strobe;
    end
  end
endmodule

// ===== verification/cvs_timing_gen_tb_top.sv
// Testbench of the camera video sync timing generator
module cvs_timing_gen_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0; // 200 MHz clock
  logic rstn = 1'b0; // Active low reset
  logic clk_en = 1'b1; // Enable
  logic [1:0] mode_sel = cvs_pkg::MODE_INTERLACE; // Readout mode pins
  logic [cvs_pkg::WORD_W-1:0] pixel_in = 12'h000; // Pixel samples
  logic pixel_strobe, line_valid, frame_valid, pixel_take; // Qualifiers
  logic [cvs_pkg::WORD_W-1:0] pixel_word; // Pixel word out
  logic [15:0] lo_run, hi_run, period; // Grabber measurements
  logic word_bad; // Nonzero word outside the image
  logic [15:0] seen_v [5]; // Row values seen
  logic [15:0] exp_v [5]; // Row values expected
  logic [2:0] snap; // Outputs before a stall
  int n_fail = 0;
  int n_tests = 0;
  always #2.5 sys_clk = ~sys_clk;
  // Pixel samples change each cycle
  always @(negedge sys_clk) pixel_in <= pixel_in + 12'h001;
  cvs_timing_gen u_dut (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .mode_sel(mode_sel),
    .pixel_in(pixel_in), .pixel_strobe(pixel_strobe), .line_valid(line_valid),
    .frame_valid(frame_valid), .pixel_word(pixel_word), .pixel_take(pixel_take));
  cvs_grabber_model u_grab (.sys_clk(sys_clk), .rstn(rstn), .pixel_strobe(pixel_strobe),
    .line_valid(line_valid), .frame_valid(frame_valid), .pixel_word(pixel_word),
    .lo_run(lo_run), .hi_run(hi_run), .period(period), .word_bad(word_bad));
  // Compare one value
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Print the counts and the verdict, then stop
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog over about 60000 cycles
  initial begin
    #300000;
    n_fail++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    // A mode change inside the frame must wait for the frame end
    repeat (50) @(negedge sys_clk);
    mode_sel = cvs_pkg::MODE_OUTLINE;
    @(negedge line_valid);
    // The grabber sees the fall one cycle after the outputs move
    repeat (2) @(negedge sys_clk);
    seen_v = '{lo_run, hi_run, period, {15'h0000, word_bad}, {15'h0000, frame_valid}};
    exp_v = '{16'h01ac, 16'h0fa0, 16'h000a, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++) check(seen_v[i], exp_v[i]);
    // A low enable freezes the outputs
    snap = {pixel_strobe, line_valid, frame_valid};
    clk_en = 1'b0;
    repeat (40) @(negedge sys_clk);
    check({13'h0000, pixel_strobe, line_valid, frame_valid}, {13'h0000, snap});
    clk_en = 1'b1;
    // Reset at the start of the second line clears the outputs
    rstn = 1'b0;
    @(negedge sys_clk);
    check({pixel_word, pixel_strobe, line_valid, frame_valid, pixel_take}, 16'h0000);
    rstn = 1'b1;
    // After reset the first line is interlace again
    @(posedge line_valid);
    // Let the grabber register the run of the low part
    repeat (2) @(negedge sys_clk);
    check(lo_run, 16'h01ac);
    check(period, 16'h000a);
    report_and_stop();
  end
endmodule
